// ---- hw/output_param_pkg.sv ----
// constants, offsets and types of the output parameter register bank
package output_param_pkg;

    // ****************************************
    // relative register numbers
    // ****************************************
    localparam logic [15:0] REG_O1_PROC_SP = 16'h001f;
    localparam logic [15:0] REG_O1_DEV_SP = 16'h0020;
    localparam logic [15:0] REG_O2_PROC_SP = 16'h0021;
    localparam logic [15:0] REG_O2_DEV_SP = 16'h0022;
    localparam logic [15:0] REG_O2_FUNC = 16'h0fdb;
    localparam logic [15:0] REG_O2_ACTION = 16'h0fdc;
    localparam logic [15:0] REG_O2_ALM_ACTION = 16'h0fdd;
    localparam logic [15:0] REG_O2_ALM_OP = 16'h0fde;
    localparam logic [15:0] REG_O2_ALM_DELAY = 16'h0fdf;
    localparam logic [15:0] REG_O2_ALM_INHIBIT = 16'h0fe0;
    localparam logic [15:0] REG_O2_CYCLE = 16'h0fe1;
    localparam logic [15:0] REG_O2_LOW = 16'h0fe2;
    localparam logic [15:0] REG_O2_HIGH = 16'h0fe3;
    // relative to absolute holding register number
    localparam logic [15:0] ABS_BASE = 16'h9c41;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [15:0] RST_PROC_SP = 16'h004d;
    localparam logic [15:0] RST_DEV_SP = 16'h06c0;
    localparam logic [15:0] RST_FUNC = 16'h0002;
    localparam logic [15:0] RST_ACTION = 16'h0001;
    localparam logic [15:0] RST_ALM_ACTION = 16'h0001;
    localparam logic [15:0] RST_ALM_OP = 16'h0001;
    localparam logic [15:0] RST_ALM_TIME = 16'h0000;
    localparam logic [15:0] RST_CYCLE_RELAY = 16'h0005;
    localparam logic [15:0] RST_CYCLE_SSR = 16'h0000;
    localparam logic [15:0] RST_LOW = 16'h0000;
    localparam logic [15:0] RST_HIGH = 16'h0064;

    // ****************************************
    // field encodings and ranges
    // ****************************************
    localparam logic [15:0] FUNC_DISABLED = 16'h0001;
    localparam logic [15:0] FUNC_PID = 16'h0002;
    localparam logic [15:0] FUNC_ONOFF = 16'h0004;
    localparam logic [15:0] FUNC_ALARM = 16'h0005;
    localparam logic [15:0] ACTION_DIRECT = 16'h0001;
    localparam logic [15:0] ACTION_REVERSE = 16'h0002;
    localparam logic [15:0] ALM_ACTION_MIN = 16'h0001;
    localparam logic [15:0] ALM_ACTION_MAX = 16'h0003;
    localparam logic [15:0] ALM_OP_MIN = 16'h0001;
    localparam logic [15:0] ALM_OP_MAX = 16'h0006;
    localparam logic [15:0] ALM_TIME_MAX = 16'h270f;
    localparam logic [15:0] CYCLE_MAX = 16'h0078;
    localparam logic [15:0] LIMIT_MAX = 16'h0064;
    localparam logic [15:0] DEV_SP_MIN = 16'h0001;
    // fractional value caps for linear input, per decimal position
    localparam logic [15:0] FV_CAP_DP0 = 16'h270f;
    localparam logic [15:0] FV_CAP_DP1 = 16'h03e7;
    localparam logic [15:0] FV_CAP_DP2 = 16'h0063;
    localparam logic [15:0] FV_CAP_DP3 = 16'h0009;

    // ****************************************
    // timing
    // ****************************************
    localparam logic [15:0] CYCLE_FAST_TENTHS = 16'h0002;
    localparam logic [15:0] TENTHS_PER_SECOND = 16'h000a;
    localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

    // ****************************************
    // answer codes
    // ****************************************
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_ADDRESS = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;

    typedef enum logic [3:0] {
        SEL_NONE,
        SEL_O1_PROC_SP,
        SEL_O1_DEV_SP,
        SEL_O2_PROC_SP,
        SEL_O2_DEV_SP,
        SEL_FUNC,
        SEL_ACTION,
        SEL_ALM_ACTION,
        SEL_ALM_OP,
        SEL_ALM_DELAY,
        SEL_ALM_INHIBIT,
        SEL_CYCLE,
        SEL_LOW,
        SEL_HIGH
    } reg_sel_t;

endpackage

// ---- hw/value_check_if.sv ----
// carrier between the register bank and its value checker
`timescale 1ns/1ps
interface value_check_if;
    import output_param_pkg::*;
    reg_sel_t sel;
    logic [15:0] value;
    logic compact;
    logic linear_input;
    logic [1:0] decimal_position_setting;
    logic [15:0] sensor_low;
    logic [15:0] sensor_high;
    logic ok;

    modport bank (output sel, value, compact, linear_input, decimal_position_setting,
        sensor_low, sensor_high, input ok);
    modport checker_end (input sel, value, compact, linear_input, decimal_position_setting,
        sensor_low, sensor_high, output ok);
endinterface

// ---- hw/value_checker.sv ----
// range and encoding check of a value written to the bank
`timescale 1ns/1ps
module value_checker
    import output_param_pkg::*;
(
    value_check_if.checker_end chk
);

    logic signed [16:0] lo;
    logic signed [16:0] hi;
    logic signed [16:0] val;
    logic signed [16:0] span;
    logic [16:0] mag;
    logic [15:0] cap;
    logic fv_ok;

    always_comb begin
        lo = {chk.sensor_low[15], chk.sensor_low};
        hi = {chk.sensor_high[15], chk.sensor_high};
        val = {chk.value[15], chk.value};
        span = hi - lo;
        mag = val[16] ? 17'(-val) : 17'(val);
        case (chk.decimal_position_setting)
            2'h0: cap = FV_CAP_DP0;
            2'h1: cap = FV_CAP_DP1;
            2'h2: cap = FV_CAP_DP2;
            default: cap = FV_CAP_DP3;
        endcase
        fv_ok = !chk.linear_input || (mag <= {1'b0, cap});
        chk.ok = 1'b0;
        case (chk.sel)
            SEL_O1_PROC_SP, SEL_O2_PROC_SP: begin
                chk.ok = (val >= lo) && (val <= hi) && fv_ok;
            end
            SEL_O1_DEV_SP, SEL_O2_DEV_SP: begin
                chk.ok = (val >= 17'sd1) && (val <= span) && fv_ok;
            end
            SEL_FUNC: begin
                // alarm code refused on large models
                chk.ok = (chk.value == FUNC_DISABLED) || (chk.value == FUNC_PID) ||
                    (chk.value == FUNC_ONOFF) || (chk.compact && chk.value == FUNC_ALARM);
            end
            SEL_ACTION: begin
                chk.ok = (chk.value == ACTION_DIRECT) || (chk.value == ACTION_REVERSE);
            end
            SEL_ALM_ACTION: begin
                chk.ok = (chk.value >= ALM_ACTION_MIN) && (chk.value <= ALM_ACTION_MAX);
            end
            SEL_ALM_OP: begin
                chk.ok = (chk.value >= ALM_OP_MIN) && (chk.value <= ALM_OP_MAX);
            end
            SEL_ALM_DELAY, SEL_ALM_INHIBIT: begin
                chk.ok = chk.value <= ALM_TIME_MAX;
            end
            SEL_CYCLE: begin
                chk.ok = chk.value <= CYCLE_MAX;
            end
            SEL_LOW, SEL_HIGH: begin
                chk.ok = chk.value <= LIMIT_MAX;
            end
            default: chk.ok = 1'b0;
        endcase
    end

endmodule

// ---- hw/output_param_register_bank.sv ----
// holding-register bank for output 2 and the output alarm setpoints
`timescale 1ns/1ps
module output_param_register_bank
    import output_param_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // model straps from pins
    input wire logic compact_strap,
    input wire logic solid_state_strap,
    // sensor context from the input block
    input wire logic linear_input,
    input wire logic [1:0] decimal_position_setting,
    input wire logic [15:0] sensor_low,
    input wire logic [15:0] sensor_high,
    // register access from the protocol engine
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [15:0] req_reg,
    input wire logic [15:0] req_data,
    output logic req_ready,
    output logic resp_valid,
    output logic [15:0] resp_data,
    output logic [7:0] resp_exception,
    output logic [15:0] resp_abs_reg,
    // parameter values to the output logic
    output logic [15:0] out2_function,
    output logic [15:0] out2_action,
    output logic [15:0] out2_alarm_action,
    output logic [15:0] out2_alarm_operation,
    output logic [15:0] out2_alarm_delay,
    output logic [15:0] out2_alarm_inhibit,
    output logic [15:0] out2_cycle_code,
    output logic [15:0] out2_cycle_tenths,
    output logic [15:0] out2_low_limit,
    output logic [15:0] out2_high_limit,
    output logic [15:0] first_output_alarm_setpoint,
    output logic [15:0] second_output_alarm_setpoint
);

    // ****************************************
    // decode
    // ****************************************
    function automatic reg_sel_t decode_reg(input logic [15:0] rel);
        case (rel)
            REG_O1_PROC_SP: decode_reg = SEL_O1_PROC_SP;
            REG_O1_DEV_SP: decode_reg = SEL_O1_DEV_SP;
            REG_O2_PROC_SP: decode_reg = SEL_O2_PROC_SP;
            REG_O2_DEV_SP: decode_reg = SEL_O2_DEV_SP;
            REG_O2_FUNC: decode_reg = SEL_FUNC;
            REG_O2_ACTION: decode_reg = SEL_ACTION;
            REG_O2_ALM_ACTION: decode_reg = SEL_ALM_ACTION;
            REG_O2_ALM_OP: decode_reg = SEL_ALM_OP;
            REG_O2_ALM_DELAY: decode_reg = SEL_ALM_DELAY;
            REG_O2_ALM_INHIBIT: decode_reg = SEL_ALM_INHIBIT;
            REG_O2_CYCLE: decode_reg = SEL_CYCLE;
            REG_O2_LOW: decode_reg = SEL_LOW;
            REG_O2_HIGH: decode_reg = SEL_HIGH;
            default: decode_reg = SEL_NONE;
        endcase
    endfunction

    // registers that only the alarm-capable compact models carry
    function automatic logic alarm_only(input reg_sel_t s);
        case (s)
            SEL_O1_PROC_SP, SEL_O1_DEV_SP, SEL_O2_PROC_SP, SEL_O2_DEV_SP,
            SEL_ALM_ACTION, SEL_ALM_OP, SEL_ALM_DELAY, SEL_ALM_INHIBIT: alarm_only = 1'b1;
            default: alarm_only = 1'b0;
        endcase
    endfunction

    // ****************************************
    // strap synchronisers and capture
    // ****************************************
    typedef enum logic {ST_SETTLE, ST_RUN} bank_state_t;

    logic [2:0] compact_sync;
    logic [2:0] solid_sync;
    logic [2:0] next_compact_sync;
    logic [2:0] next_solid_sync;
    bank_state_t state;
    bank_state_t next_state;
    logic [1:0] settle_count;
    logic [1:0] next_settle_count;
    logic compact;
    logic next_compact;
    logic solid_state;
    logic next_solid_state;
    logic straps_agree;

    always_comb begin
        next_compact_sync = {compact_sync[1:0], compact_strap};
        next_solid_sync = {solid_sync[1:0], solid_state_strap};
        // stages 1 and 2 of each chain are compared, never stage 0
        straps_agree = (compact_sync[1] == compact_sync[2]) && (solid_sync[1] == solid_sync[2]);
        next_state = state;
        next_settle_count = settle_count;
        next_compact = compact;
        next_solid_state = solid_state;
        case (state)
            ST_SETTLE: begin
                if (settle_count != STRAP_SETTLE_CYCLES) begin
                    next_settle_count = settle_count + 2'h1;
                end else if (straps_agree) begin
                    next_compact = compact_sync[2];
                    next_solid_state = solid_sync[2];
                    next_state = ST_RUN;
                end
            end
            ST_RUN: next_state = ST_RUN;
            default: next_state = ST_SETTLE;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            compact_sync <= 3'h0;
            solid_sync <= 3'h0;
            state <= ST_SETTLE;
            settle_count <= 2'h0;
            compact <= 1'b0;
            solid_state <= 1'b0;
        end else begin
            compact_sync <= next_compact_sync;
            solid_sync <= next_solid_sync;
            state <= next_state;
            settle_count <= next_settle_count;
            compact <= next_compact;
            solid_state <= next_solid_state;
        end
    end

    // ****************************************
    // value checker
    // ****************************************
    value_check_if chk ();
    reg_sel_t sel;
    logic accept;
    logic legal_addr;

    assign sel = decode_reg(req_reg);
    assign chk.sel = sel;
    assign chk.value = req_data;
    assign chk.compact = compact;
    assign chk.linear_input = linear_input;
    assign chk.decimal_position_setting = decimal_position_setting;
    assign chk.sensor_low = sensor_low;
    assign chk.sensor_high = sensor_high;

    value_checker u_checker (
        .chk(chk.checker_end)
    );

    // alarm registers absent on large models
    assign legal_addr = (sel != SEL_NONE) && (compact || !alarm_only(sel));
    assign req_ready = (state == ST_RUN);
    assign accept = req_valid && req_ready;

    // ****************************************
    // parameter storage
    // ****************************************
    logic [15:0] o1_sp;
    logic [15:0] o2_sp;
    logic o1_sp_written;
    logic o2_sp_written;
    logic cycle_written;
    logic [15:0] next_o1_sp;
    logic [15:0] next_o2_sp;
    logic next_o1_sp_written;
    logic next_o2_sp_written;
    logic next_cycle_written;
    logic [15:0] next_function;
    logic [15:0] next_action;
    logic [15:0] next_alarm_action;
    logic [15:0] next_alarm_operation;
    logic [15:0] next_alarm_delay;
    logic [15:0] next_alarm_inhibit;
    logic [15:0] next_cycle_code;
    logic [15:0] next_low_limit;
    logic [15:0] next_high_limit;
    logic do_write;

    always_comb begin
        do_write = accept && req_write && legal_addr && chk.ok;
        next_o1_sp = o1_sp;
        next_o2_sp = o2_sp;
        next_o1_sp_written = o1_sp_written;
        next_o2_sp_written = o2_sp_written;
        next_cycle_written = cycle_written;
        next_function = out2_function;
        next_action = out2_action;
        next_alarm_action = out2_alarm_action;
        next_alarm_operation = out2_alarm_operation;
        next_alarm_delay = out2_alarm_delay;
        next_alarm_inhibit = out2_alarm_inhibit;
        next_cycle_code = out2_cycle_code;
        next_low_limit = out2_low_limit;
        next_high_limit = out2_high_limit;
        if (state == ST_SETTLE && next_state == ST_RUN && !cycle_written) begin
            next_cycle_code = next_solid_state ? RST_CYCLE_SSR : RST_CYCLE_RELAY;
        end
        if (do_write) begin
            case (sel)
                SEL_O1_PROC_SP, SEL_O1_DEV_SP: begin
                    next_o1_sp = req_data;
                    next_o1_sp_written = 1'b1;
                end
                SEL_O2_PROC_SP, SEL_O2_DEV_SP: begin
                    next_o2_sp = req_data;
                    next_o2_sp_written = 1'b1;
                end
                SEL_FUNC: next_function = req_data;
                SEL_ACTION: next_action = req_data;
                SEL_ALM_ACTION: next_alarm_action = req_data;
                SEL_ALM_OP: next_alarm_operation = req_data;
                SEL_ALM_DELAY: next_alarm_delay = req_data;
                SEL_ALM_INHIBIT: next_alarm_inhibit = req_data;
                SEL_CYCLE: begin
                    next_cycle_code = req_data;
                    next_cycle_written = 1'b1;
                end
                SEL_LOW: next_low_limit = req_data;
                SEL_HIGH: next_high_limit = req_data;
                default: next_o1_sp = o1_sp;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            o1_sp <= RST_PROC_SP;
            o2_sp <= RST_PROC_SP;
            o1_sp_written <= 1'b0;
            o2_sp_written <= 1'b0;
            cycle_written <= 1'b0;
            out2_function <= RST_FUNC;
            out2_action <= RST_ACTION;
            out2_alarm_action <= RST_ALM_ACTION;
            out2_alarm_operation <= RST_ALM_OP;
            out2_alarm_delay <= RST_ALM_TIME;
            out2_alarm_inhibit <= RST_ALM_TIME;
            out2_cycle_code <= RST_CYCLE_RELAY;
            out2_low_limit <= RST_LOW;
            out2_high_limit <= RST_HIGH;
        end else begin
            o1_sp <= next_o1_sp;
            o2_sp <= next_o2_sp;
            o1_sp_written <= next_o1_sp_written;
            o2_sp_written <= next_o2_sp_written;
            cycle_written <= next_cycle_written;
            out2_function <= next_function;
            out2_action <= next_action;
            out2_alarm_action <= next_alarm_action;
            out2_alarm_operation <= next_alarm_operation;
            out2_alarm_delay <= next_alarm_delay;
            out2_alarm_inhibit <= next_alarm_inhibit;
            out2_cycle_code <= next_cycle_code;
            out2_low_limit <= next_low_limit;
            out2_high_limit <= next_high_limit;
        end
    end

    assign first_output_alarm_setpoint = o1_sp;
    assign second_output_alarm_setpoint = o2_sp;

    // ****************************************
    // cycle time in tenths of a second
    // ****************************************
    logic [15:0] next_cycle_tenths;

    always_comb begin
        // code 0 is the fast cycle
        if (next_cycle_code == 16'h0000) begin
            next_cycle_tenths = CYCLE_FAST_TENTHS;
        end else begin
            next_cycle_tenths = 16'(next_cycle_code * TENTHS_PER_SECOND);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            out2_cycle_tenths <= 16'(RST_CYCLE_RELAY * TENTHS_PER_SECOND);
        end else begin
            out2_cycle_tenths <= next_cycle_tenths;
        end
    end

    // ****************************************
    // answer
    // ****************************************
    logic [15:0] read_value;
    logic next_resp_valid;
    logic [15:0] next_resp_data;
    logic [7:0] next_resp_exception;
    logic [15:0] next_resp_abs_reg;

    always_comb begin
        case (sel)
            // band setpoint reads 1728 until either setpoint of its output is written
            SEL_O1_PROC_SP: read_value = o1_sp;
            SEL_O1_DEV_SP: read_value = o1_sp_written ? o1_sp : RST_DEV_SP;
            SEL_O2_PROC_SP: read_value = o2_sp;
            SEL_O2_DEV_SP: read_value = o2_sp_written ? o2_sp : RST_DEV_SP;
            SEL_FUNC: read_value = out2_function;
            SEL_ACTION: read_value = out2_action;
            SEL_ALM_ACTION: read_value = out2_alarm_action;
            SEL_ALM_OP: read_value = out2_alarm_operation;
            SEL_ALM_DELAY: read_value = out2_alarm_delay;
            SEL_ALM_INHIBIT: read_value = out2_alarm_inhibit;
            SEL_CYCLE: read_value = out2_cycle_code;
            SEL_LOW: read_value = out2_low_limit;
            SEL_HIGH: read_value = out2_high_limit;
            default: read_value = 16'h0000;
        endcase
        next_resp_valid = accept;
        next_resp_data = resp_data;
        next_resp_exception = resp_exception;
        next_resp_abs_reg = resp_abs_reg;
        if (accept) begin
            next_resp_abs_reg = 16'(req_reg + ABS_BASE);
            if (!legal_addr) begin
                next_resp_exception = EXC_ADDRESS;
                next_resp_data = 16'h0000;
            end else if (req_write && !chk.ok) begin
                next_resp_exception = EXC_VALUE;
                next_resp_data = read_value;
            end else begin
                next_resp_exception = EXC_NONE;
                next_resp_data = req_write ? req_data : read_value;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            resp_valid <= 1'b0;
            resp_data <= 16'h0000;
            resp_exception <= EXC_NONE;
            resp_abs_reg <= 16'h0000;
        end else begin
            resp_valid <= next_resp_valid;
            resp_data <= next_resp_data;
            resp_exception <= next_resp_exception;
            resp_abs_reg <= next_resp_abs_reg;
        end
    end

endmodule

// ---- sim/output_param_properties.sv ----
// assertions on the register bank ports
`timescale 1ns/1ps
module output_param_properties import output_param_pkg::*; (
    input wire logic clock, rstn, req_valid, req_ready, resp_valid,
    input wire logic [15:0] req_reg, resp_abs_reg, out2_function, out2_action, out2_cycle_code,
    input wire logic [15:0] out2_cycle_tenths, out2_low_limit, out2_high_limit, out2_alarm_delay,
    input wire logic [15:0] out2_alarm_action, out2_alarm_operation, out2_alarm_inhibit);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_answer_abs: assert property (req_valid && req_ready |=>
        resp_valid && resp_abs_reg == $past(req_reg) + ABS_BASE) else $error("bad answer");
    a_func_code: assert property (out2_function inside {1, 2, 4, 5}) else $error("func");
    a_action_code: assert property (out2_action inside {1, 2}) else $error("action");
    a_cycle_scale: assert property (out2_cycle_tenths == (out2_cycle_code == 0 ?
        CYCLE_FAST_TENTHS : out2_cycle_code * TENTHS_PER_SECOND)) else $error("cycle");
    a_limit_max: assert property (out2_high_limit <= 100 && out2_low_limit <= 100)
        else $error("limit");
    a_alarm_code: assert property (out2_alarm_action inside {[1:3]}) else $error("alm");
    a_op_code: assert property (out2_alarm_operation inside {[1:6]}) else $error("op");
    a_delay_max: assert property (out2_alarm_delay <= 9999) else $error("delay");
    a_inhibit_max: assert property (out2_alarm_inhibit <= 9999) else $error("inhibit");
    cover property (req_valid && req_ready && req_reg == 16'h21);
    cover property (out2_cycle_code == 16'h0);
    cover property (out2_function == 16'h5);
endmodule

// ---- sim/reg_master_model.sv ----
// protocol master issuing one register request at a time
`timescale 1ns/1ps
module reg_master_model (
    input wire logic clock, req_ready, resp_valid,
    input wire logic [15:0] resp_data, resp_abs_reg,
    input wire logic [7:0] resp_exception,
    output logic req_valid, req_write,
    output logic [15:0] req_reg, req_data);
    initial {req_valid, req_write, req_reg, req_data} = 34'h0;
    // large-model alarm access only to provoke a refusal
    task automatic xfer(input logic w, input logic [15:0] r, d,
        output logic [15:0] rd, ab, output logic [7:0] ex, output logic ok);
        int n = 0;
        @(negedge clock);
        while (req_ready !== 1'b1 && n++ < 50) @(negedge clock);
        {req_valid, req_write, req_reg, req_data} = {1'b1, w, r, d};
        @(negedge clock);
        // released lines show the inverse, never a stale copy
        {req_valid, req_write, req_reg, req_data} = {1'b0, ~w, ~r, ~d};
        {rd, ab, ex, ok} = {resp_data, resp_abs_reg, resp_exception, resp_valid === 1'b1};
    endtask
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the output parameter register bank
`timescale 1ns/1ps
module tb_top import output_param_pkg::*;;
    logic clock, rstn, compact_strap, solid_state_strap, linear_input, req_valid, req_write, ok;
    logic req_ready, resp_valid;
    logic [1:0] decimal_position_setting;
    logic [7:0] resp_exception, ex, e;
    logic [15:0] sensor_low, sensor_high, req_reg, req_data, resp_data, resp_abs_reg, rd, ab, r, d;
    logic [15:0] v, out2_function, out2_action, out2_alarm_action, out2_alarm_operation;
    logic [15:0] out2_alarm_delay, out2_alarm_inhibit, out2_cycle_code, out2_cycle_tenths;
    logic [15:0] out2_low_limit, out2_high_limit, first_output_alarm_setpoint;
    logic [15:0] second_output_alarm_setpoint;
    int num_errors, n_checks, cycles;
    // linear, register, data, answer code, value held afterwards
    logic [55:0] wt[22] = '{56'h0fdb0003030002, 56'h0fdb0005000005,
        56'h0fdb0004000004, 56'h0fdb0001000001, 56'h0fdc0000030001,
        56'h0fdc0002000002, 56'h0fe10079030005, 56'h0fe10000000000,
        56'h0fe30065030064, 56'h0fe20064000064, 56'h0fdd0004030001,
        56'h0fde0007030001, 56'h0fdf270f00270f, 56'h0fe02710030000,
        56'h00230001020000, 56'h002103e903004d, 56'h00210064000064,
        56'h00220000030064, 56'h002000000306c0, 56'h002003e80003e8,
        56'h101f00640303e8, 56'h101f0063000063};
    output_param_register_bank dut_u (.*);
    reg_master_model master_u (.*);
    initial forever #20 clock = ~clock;
    task automatic check(input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) num_errors++;
        if (seen !== exp) $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    endtask
    task automatic acc(input logic w, input logic [7:0] e, input logic [15:0] r, d, v);
        master_u.xfer(w, r, d, rd, ab, ex, ok);
        check({7'h0, ok, ex}, {8'h1, e});
        check(ab, 16'(r + ABS_BASE));
        check(rd, v);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // hang guard, far above the hundred or so cycles the run needs
    // one process, so the count and the stop can never race each other
    always @(posedge clock) begin
        if (++cycles == 3000) begin
            num_errors++;
            stop_test();
        end
    end
    initial begin
        {clock, linear_input, decimal_position_setting} = 4'h2;
        {sensor_low, sensor_high} = {16'h0, 16'h3e8};
        {rstn, compact_strap, solid_state_strap} = 3'b010;
        repeat (5) @(negedge clock);
        rstn = 1'b1;
        for (int i = 0; i < 22; i++) begin
            {linear_input, r, d, e, v} = {wt[i][52], 4'h0, wt[i][51:0]};
            acc(1'b1, e, r, d, v);
            acc(1'b0, e == 8'h3 ? 8'h0 : e, r, 16'h0, v);
        end
        check(first_output_alarm_setpoint, 16'h63);
        check(second_output_alarm_setpoint, 16'h64);
        check(out2_alarm_inhibit, RST_ALM_TIME);
        check(out2_cycle_tenths, CYCLE_FAST_TENTHS);
        check(out2_function, FUNC_DISABLED);
        $display("test compact model done");
        {rstn, compact_strap, solid_state_strap} = 3'b001;
        repeat (5) @(negedge clock);
        rstn = 1'b1;
        acc(1'b0, 8'h0, 16'hfe1, 16'h0, 16'h0);
        acc(1'b1, 8'h3, 16'hfdb, 16'h5, 16'h2);
        acc(1'b1, 8'h2, 16'hfde, 16'h1, 16'h0);
        check(out2_alarm_operation, RST_ALM_OP);
        $display("test large model done");
        stop_test();
    end
endmodule
bind output_param_register_bank output_param_properties props_u (.clock(clock), .rstn(rstn),
    .req_valid(req_valid), .req_ready(req_ready), .resp_valid(resp_valid), .req_reg(req_reg),
    .resp_abs_reg(resp_abs_reg), .out2_function(out2_function), .out2_action(out2_action),
    .out2_cycle_code(out2_cycle_code), .out2_cycle_tenths(out2_cycle_tenths),
    .out2_low_limit(out2_low_limit), .out2_high_limit(out2_high_limit),
    .out2_alarm_delay(out2_alarm_delay), .out2_alarm_inhibit(out2_alarm_inhibit),
    .out2_alarm_action(out2_alarm_action), .out2_alarm_operation(out2_alarm_operation));
